// ===== hw/gpipr_map.svh
// register offsets, reset values and field positions of the input pull and polarity block
`ifndef GPIPR_MAP_SVH
`define GPIPR_MAP_SVH
`define GPIPR_OFS_ROW_IRQ_STATUS 8'h13
`define GPIPR_OFS_COL_IRQ_STATUS 8'h14
`define GPIPR_OFS_ROW_LEVEL 8'h15
`define GPIPR_OFS_COL_LEVEL 8'h16
`define GPIPR_OFS_PULL_ROWS_LOW 8'h17
`define GPIPR_OFS_PULL_ROWS_HIGH 8'h18
`define GPIPR_OFS_PULL_COLS_LOW 8'h19
`define GPIPR_OFS_PULL_COLS_HIGH 8'h1A
`define GPIPR_OFS_ROW_POLARITY 8'h1B
`define GPIPR_RST_PULL_ROWS_LOW 8'h55
`define GPIPR_RST_PULL_ROWS_HIGH 8'h05
`define GPIPR_RST_PULL_COLS_LOW 8'h51
`define GPIPR_RST_PULL_COLS_HIGH 8'h01
`define GPIPR_RST_ROW_POLARITY 8'h00
`define GPIPR_MASK_PULL_ROWS_HIGH 8'h0F
`define GPIPR_MASK_PULL_COLS_HIGH 8'h03
`define GPIPR_MASK_ROW_POLARITY 8'h3F
`define GPIPR_ROW_COUNT 6
`define GPIPR_COL_COUNT 5
`define GPIPR_PULL_WEAK_UP 2'b00
`define GPIPR_PULL_WEAK_DOWN 2'b01
`define GPIPR_PULL_STRONG_UP 2'b10
`define GPIPR_PULL_NONE 2'b11
`endif

// ===== hw/gpipr_pkg.sv
// types shared by the input pull and polarity block
package gpipr_pkg;
    typedef logic [7:0] gpipr_byte_t;
    typedef logic [1:0] gpipr_pull_code_t;
    typedef struct packed {
        logic weakUp;
        logic weakDown;
        logic strongUp;
    } gpipr_pull_drive_t;
    typedef enum logic [2:0] {
        GPIPR_IDLE = 3'b001,
        GPIPR_READ = 3'b010,
        GPIPR_WRITE = 3'b100
    } gpipr_access_t;
endpackage

// ===== hw/gpipr_decode_if.sv
// pull codes in and resistor enables out, between the top and the decoder
`timescale 1ns/1ps
interface gpipr_decode_if;
    import gpipr_pkg::*;
    gpipr_pull_code_t code [11];
    gpipr_pull_drive_t drive [11];
    modport owner (output code, input drive);
    modport decoder (input code, output drive);
endinterface

// ===== hw/gpipr_pull_decode.sv
// decodes each 2-bit pull code into registered resistor enables
`timescale 1ns/1ps
`include "gpipr_map.svh"
module gpipr_pull_decode
    import gpipr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pull codes and enables
    gpipr_decode_if.decoder dec
);
    gpipr_pull_drive_t drive [11];
    gpipr_pull_drive_t next_drive [11];

    genvar g;
    generate
        for (g = 0; g < 11; g++) begin : gen_pin
            always_comb begin
                next_drive[g] = '0;
                unique case (dec.code[g])
                    `GPIPR_PULL_WEAK_UP: next_drive[g].weakUp = 1'b1;
                    `GPIPR_PULL_WEAK_DOWN: next_drive[g].weakDown = 1'b1;
                    `GPIPR_PULL_STRONG_UP: next_drive[g].strongUp = 1'b1;
                    `GPIPR_PULL_NONE: next_drive[g] = '0;
                endcase
            end
            // enables stay off during reset and follow the codes one edge later
            always_ff @(posedge clock) begin
                if (rst) begin
                    drive[g] <= '0;
                end else begin
                    drive[g] <= next_drive[g];
                end
            end
            assign dec.drive[g] = drive[g];

            property p_decode;
                @(posedge clock) disable iff (rst)
                1'b1 |=> drive[g] == {$past(dec.code[g]) == `GPIPR_PULL_WEAK_UP,
                    $past(dec.code[g]) == `GPIPR_PULL_WEAK_DOWN, $past(dec.code[g]) == `GPIPR_PULL_STRONG_UP};
            endproperty
            a_decode: assert property (p_decode)
                else $error("pull decode mismatch");

            property p_one_resistor;
                @(posedge clock) disable iff (rst)
                $onehot0(drive[g]);
            endproperty
            a_one_resistor: assert property (p_one_resistor)
                else $error("more than one resistor enabled");
        end
    endgenerate
endmodule

// ===== hw/gpipr_input_regs.sv
// row and column input status, pull selection and row interrupt polarity registers
`timescale 1ns/1ps
`include "gpipr_map.svh"
module gpipr_input_regs
    import gpipr_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    output logic regReadValid,
    // pin levels
    input wire logic [5:0] rowLevel,
    input wire logic [4:0] columnLevel,
    // resistor enables, one bit per pin, rows then columns
    output logic [10:0] pullWeakUp,
    output logic [10:0] pullWeakDown,
    output logic [10:0] pullStrongUp,
    // interrupt flags toward the enable and summary logic
    output logic [5:0] rowIrqFlag
);
    gpipr_byte_t pullRowsLow, pullRowsHigh, pullColsLow, pullColsHigh, rowPolarity;
    gpipr_byte_t next_pullRowsLow, next_pullRowsHigh, next_pullColsLow, next_pullColsHigh, next_rowPolarity;
    logic [5:0] rowFlag, next_rowFlag;
    gpipr_byte_t readData, next_readData;
    logic readValid, next_readValid;
    gpipr_access_t access;
    logic [5:0] rowActive;

    gpipr_decode_if dec ();

    always_comb begin
        access = GPIPR_IDLE;
        if (regWrite) begin
            access = GPIPR_WRITE;
        end else if (regRead) begin
            access = GPIPR_READ;
        end
    end

    // configuration registers
    always_comb begin
        next_pullRowsLow = pullRowsLow;
        next_pullRowsHigh = pullRowsHigh;
        next_pullColsLow = pullColsLow;
        next_pullColsHigh = pullColsHigh;
        next_rowPolarity = rowPolarity;
        if (access == GPIPR_WRITE) begin
            unique case (regAddr)
                `GPIPR_OFS_PULL_ROWS_LOW: next_pullRowsLow = regWriteData;
                `GPIPR_OFS_PULL_ROWS_HIGH: next_pullRowsHigh = regWriteData & `GPIPR_MASK_PULL_ROWS_HIGH;
                `GPIPR_OFS_PULL_COLS_LOW: next_pullColsLow = regWriteData;
                `GPIPR_OFS_PULL_COLS_HIGH: next_pullColsHigh = regWriteData & `GPIPR_MASK_PULL_COLS_HIGH;
                `GPIPR_OFS_ROW_POLARITY: next_rowPolarity = regWriteData & `GPIPR_MASK_ROW_POLARITY;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pullRowsLow <= `GPIPR_RST_PULL_ROWS_LOW;
            pullRowsHigh <= `GPIPR_RST_PULL_ROWS_HIGH;
            pullColsLow <= `GPIPR_RST_PULL_COLS_LOW;
            pullColsHigh <= `GPIPR_RST_PULL_COLS_HIGH;
            rowPolarity <= `GPIPR_RST_ROW_POLARITY;
        end else begin
            pullRowsLow <= next_pullRowsLow;
            pullRowsHigh <= next_pullRowsHigh;
            pullColsLow <= next_pullColsLow;
            pullColsHigh <= next_pullColsHigh;
            rowPolarity <= next_rowPolarity;
        end
    end

    // level-triggered flags: a still-active pin keeps its flag set through a status read, which clears only inactive pins
    assign rowActive = ~(rowLevel ^ rowPolarity[5:0]);
    always_comb begin
        next_rowFlag = rowFlag;
        if (access == GPIPR_READ && regAddr == `GPIPR_OFS_ROW_IRQ_STATUS) begin
            next_rowFlag = '0;
        end
        next_rowFlag = next_rowFlag | rowActive;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rowFlag <= '0;
        end else begin
            rowFlag <= next_rowFlag;
        end
    end
    assign rowIrqFlag = rowFlag;

    // read port; unmapped offsets read zero
    always_comb begin
        next_readData = '0;
        next_readValid = 1'b0;
        if (access == GPIPR_READ) begin
            next_readValid = 1'b1;
            unique case (regAddr)
                `GPIPR_OFS_ROW_IRQ_STATUS: next_readData = {2'b00, rowFlag};
                `GPIPR_OFS_ROW_LEVEL: next_readData = {2'b00, rowLevel};
                `GPIPR_OFS_COL_LEVEL: next_readData = {3'b000, columnLevel};
                `GPIPR_OFS_PULL_ROWS_LOW: next_readData = pullRowsLow;
                `GPIPR_OFS_PULL_ROWS_HIGH: next_readData = pullRowsHigh;
                `GPIPR_OFS_PULL_COLS_LOW: next_readData = pullColsLow;
                `GPIPR_OFS_PULL_COLS_HIGH: next_readData = pullColsHigh;
                `GPIPR_OFS_ROW_POLARITY: next_readData = rowPolarity;
                default: next_readData = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            readData <= '0;
            readValid <= 1'b0;
        end else begin
            readData <= next_readData;
            readValid <= next_readValid;
        end
    end
    assign regReadData = readData;
    assign regReadValid = readValid;

    // pins 0..5 rows, 6..10 columns
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dec.code[i] = pullRowsLow[2*i +: 2];
            dec.code[6+i] = pullColsLow[2*i +: 2];
        end
        dec.code[4] = pullRowsHigh[1:0];
        dec.code[5] = pullRowsHigh[3:2];
        dec.code[10] = pullColsHigh[1:0];
    end

    gpipr_pull_decode u_decode (
        .clock(clock),
        .rst(rst),
        .dec(dec.decoder)
    );

    genvar g;
    generate
        for (g = 0; g < 11; g++) begin : gen_out
            assign pullWeakUp[g] = dec.drive[g].weakUp;
            assign pullWeakDown[g] = dec.drive[g].weakDown;
            assign pullStrongUp[g] = dec.drive[g].strongUp;
        end
    endgenerate

    property p_col_level;
        @(posedge clock) disable iff (rst)
        regRead && !regWrite && regAddr == `GPIPR_OFS_COL_LEVEL
        |=> regReadValid && regReadData == {3'b000, $past(columnLevel)};
    endproperty
    a_col_level: assert property (p_col_level)
        else $error("column level read wrong");

    property p_rows_low_reset;
        @(posedge clock)
        rst |=> pullRowsLow == `GPIPR_RST_PULL_ROWS_LOW;
    endproperty
    a_rows_low_reset: assert property (p_rows_low_reset)
        else $error("row pull low reset wrong");

    property p_rows_low_write;
        @(posedge clock) disable iff (rst)
        regWrite && regAddr == `GPIPR_OFS_PULL_ROWS_LOW
        |=> pullRowsLow == $past(regWriteData);
    endproperty
    a_rows_low_write: assert property (p_rows_low_write)
        else $error("row pull low write wrong");

    property p_rows_high_mask;
        @(posedge clock) disable iff (rst)
        regWrite && regAddr == `GPIPR_OFS_PULL_ROWS_HIGH
        |=> pullRowsHigh == {4'h0, $past(regWriteData[3:0])};
    endproperty
    a_rows_high_mask: assert property (p_rows_high_mask)
        else $error("row pull high write wrong");

    property p_rows_high_reset;
        @(posedge clock)
        rst |=> pullRowsHigh == `GPIPR_RST_PULL_ROWS_HIGH;
    endproperty
    a_rows_high_reset: assert property (p_rows_high_reset)
        else $error("row pull high reset wrong");

    property p_cols_low_reset;
        @(posedge clock)
        rst |=> pullColsLow == `GPIPR_RST_PULL_COLS_LOW;
    endproperty
    a_cols_low_reset: assert property (p_cols_low_reset)
        else $error("column pull low reset wrong");

    property p_cols_low_write;
        @(posedge clock) disable iff (rst)
        regWrite && regAddr == `GPIPR_OFS_PULL_COLS_LOW
        |=> pullColsLow == $past(regWriteData);
    endproperty
    a_cols_low_write: assert property (p_cols_low_write)
        else $error("column pull low write wrong");

    property p_cols_high_reset;
        @(posedge clock)
        rst |=> pullColsHigh == `GPIPR_RST_PULL_COLS_HIGH;
    endproperty
    a_cols_high_reset: assert property (p_cols_high_reset)
        else $error("column pull high reset wrong");

    property p_cols_high_mask;
        @(posedge clock) disable iff (rst)
        regWrite && regAddr == `GPIPR_OFS_PULL_COLS_HIGH
        |=> pullColsHigh == {6'h00, $past(regWriteData[1:0])};
    endproperty
    a_cols_high_mask: assert property (p_cols_high_mask)
        else $error("column pull high write wrong");

    property p_polarity_write;
        @(posedge clock) disable iff (rst)
        regWrite && regAddr == `GPIPR_OFS_ROW_POLARITY
        |=> rowPolarity == {2'b00, $past(regWriteData[5:0])};
    endproperty
    a_polarity_write: assert property (p_polarity_write)
        else $error("polarity write wrong");

    property p_polarity_set;
        @(posedge clock) disable iff (rst)
        1'b1 |=> (rowIrqFlag | ($past(rowLevel) ^ $past(rowPolarity[5:0]))) == 6'h3F;
    endproperty
    a_polarity_set: assert property (p_polarity_set)
        else $error("row flag not set on active level");

    property p_flag_needs_level;
        @(posedge clock) disable iff (rst)
        1'b1 |=> (rowIrqFlag & ~$past(rowIrqFlag) & ($past(rowLevel) ^ $past(rowPolarity[5:0]))) == 6'h00;
    endproperty
    a_flag_needs_level: assert property (p_flag_needs_level)
        else $error("row flag set on inactive level");

    property p_flag_sticky;
        @(posedge clock) disable iff (rst)
        !(regRead && !regWrite && regAddr == `GPIPR_OFS_ROW_IRQ_STATUS)
        |=> (rowIrqFlag & $past(rowIrqFlag)) == $past(rowIrqFlag);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("row flag dropped without read");

    property p_clear_on_read;
        @(posedge clock) disable iff (rst)
        regRead && !regWrite && regAddr == `GPIPR_OFS_ROW_IRQ_STATUS
        |=> rowIrqFlag == ~($past(rowLevel) ^ $past(rowPolarity[5:0]));
    endproperty
    a_clear_on_read: assert property (p_clear_on_read)
        else $error("flags not cleared by read");

    property p_flag_reset;
        @(posedge clock)
        rst |=> rowIrqFlag == 6'h00 && !regReadValid && regReadData == 8'h00;
    endproperty
    a_flag_reset: assert property (p_flag_reset)
        else $error("flags or read port not cleared by reset");

    property p_reserved_zero;
        @(posedge clock) disable iff (rst)
        pullColsHigh[7:2] == 6'h00 && rowPolarity[7:6] == 2'b00
        && pullRowsHigh[7:4] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_unmapped_zero;
        @(posedge clock) disable iff (rst)
        regRead && !regWrite && (regAddr < `GPIPR_OFS_ROW_IRQ_STATUS || regAddr > `GPIPR_OFS_ROW_POLARITY)
        |=> regReadValid && regReadData == 8'h00;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");

    property p_read_pulse;
        @(posedge clock) disable iff (rst)
        !regRead |=> !regReadValid;
    endproperty
    a_read_pulse: assert property (p_read_pulse)
        else $error("read valid without read");

    property p_read_answer;
        @(posedge clock) disable iff (rst)
        regRead && !regWrite |=> regReadValid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");

    property p_write_wins;
        @(posedge clock) disable iff (rst)
        regWrite |=> !regReadValid;
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("read answered during write");

    property p_idle_data_zero;
        @(posedge clock) disable iff (rst)
        !regRead || regWrite |=> regReadData == 8'h00;
    endproperty
    a_idle_data_zero: assert property (p_idle_data_zero)
        else $error("read data not zero without read");
endmodule

// ===== testbench/gpipr_host_model.sv
// host processor model driving the register port of the input block
`timescale 1ns/1ps
module gpipr_host_model (
    // clock
    input wire logic clock,
    // register port toward the device
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWriteData,
    input wire logic [7:0] regReadData,
    input wire logic regReadValid
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWriteData = 8'h00;
    end
    // after a strobe the bus is scrambled so stale values never look valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        regAddr = addr;
        regWriteData = data;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        regAddr = ~addr;
        regWriteData = ~data;
    endtask
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic valid);
        @(negedge clock);
        regAddr = addr;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        regAddr = ~addr;
        data = regReadData;
        valid = regReadValid;
    endtask
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the input pull and polarity registers
`timescale 1ns/1ps
module tb_top;
    import gpipr_pkg::*;
    typedef struct {gpipr_byte_t addr; gpipr_byte_t wdata; gpipr_byte_t expData;} gpipr_row_t;
    logic clock;
    logic rst;
    logic regWrite, regRead, regReadValid;
    logic [7:0] regAddr, regWriteData, regReadData;
    logic [5:0] rowLevel, rowIrqFlag;
    logic [4:0] columnLevel;
    logic [10:0] pullWeakUp, pullWeakDown, pullStrongUp;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    gpipr_byte_t rdData;
    logic rdValid;
    // write then read back; reserved bits, read-only and unmapped places included
    gpipr_row_t rows [7] = '{'{8'h17, 8'hA4, 8'hA4}, '{8'h18, 8'hFF, 8'h0F}, '{8'h19, 8'h3C, 8'h3C},
        '{8'h1A, 8'hFF, 8'h03}, '{8'h1B, 8'hFF, 8'h3F}, '{8'h16, 8'hFF, 8'h15}, '{8'h20, 8'hFF, 8'h00}};
    gpipr_row_t resetRows [5] = '{'{8'h17, 8'h00, 8'h55}, '{8'h18, 8'h00, 8'h05}, '{8'h19, 8'h00, 8'h51},
        '{8'h1A, 8'h00, 8'h01}, '{8'h1B, 8'h00, 8'h00}};

    gpipr_host_model host (.clock(clock), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid));
    gpipr_input_regs dut (.clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .rowLevel(rowLevel), .columnLevel(columnLevel),
        .pullWeakUp(pullWeakUp), .pullWeakDown(pullWeakDown), .pullStrongUp(pullStrongUp),
        .rowIrqFlag(rowIrqFlag));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic report_and_stop;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp_byte(gpipr_byte_t got, gpipr_byte_t exp, string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_vec(logic [10:0] got, logic [10:0] exp, string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic read_check(gpipr_byte_t addr, gpipr_byte_t exp, string what);
        host.rd(addr, rdData, rdValid);
        cmp_vec({10'h000, rdValid}, 11'h001, "read valid");
        cmp_byte(rdData, exp, what);
    endtask

    task automatic check_reset;
        foreach (resetRows[i]) begin
            read_check(resetRows[i].addr, resetRows[i].expData, "reset value");
        end
        cmp_vec(pullWeakDown, 11'h77F, "reset pull down");
        cmp_vec(pullWeakUp, 11'h080, "reset pull up");
        cmp_vec(pullStrongUp, 11'h000, "reset strong up");
        cmp_vec({5'h00, rowIrqFlag}, 11'h000, "reset flags");
    endtask

    // a hung run still ends in the closing report
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        rowLevel = 6'h3F;
        columnLevel = 5'h15;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        check_reset();
        foreach (rows[i]) begin
            host.wr(rows[i].addr, rows[i].wdata);
            read_check(rows[i].addr, rows[i].expData, "readback");
        end
        repeat (2) @(negedge clock);
        cmp_vec(pullWeakUp, 11'h241, "weak up");
        cmp_vec(pullWeakDown, 11'h002, "weak down");
        cmp_vec(pullStrongUp, 11'h00C, "strong up");
        cmp_vec({5'h00, rowIrqFlag}, 11'h03F, "active high set");
        rowLevel = 6'h00;
        read_check(8'h13, 8'h3F, "flags read");
        cmp_vec({5'h00, rowIrqFlag}, 11'h000, "cleared on read");
        host.wr(8'h1B, 8'h00);
        rowLevel = 6'h3F;
        // polarity swap may latch a transient flag, so clear it unchecked
        host.rd(8'h13, rdData, rdValid);
        cmp_vec({5'h00, rowIrqFlag}, 11'h000, "idle low polarity");
        rowLevel = 6'h3E;
        repeat (2) @(negedge clock);
        cmp_vec({5'h00, rowIrqFlag}, 11'h001, "active low set");
        read_check(8'h13, 8'h01, "flag pending");
        cmp_vec({5'h00, rowIrqFlag}, 11'h001, "still active");
        rowLevel = 6'h3F;
        read_check(8'h13, 8'h01, "sticky flag");
        read_check(8'h13, 8'h00, "flag gone");
        columnLevel = 5'h0A;
        read_check(8'h16, 8'h0A, "live columns");
        @(negedge clock);
        rst = 1'b1;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        check_reset();
        report_and_stop();
    end
endmodule
